// [hdl/hsrw_pkg.sv]
// Package: addresses, field positions, codes and carriers of the status window
package hsrw_pkg;
  // Host I/O register addresses
  localparam logic [15:0] IO_INT_STATUS = 16'h02D0;
  localparam logic [15:0] IO_VISUAL_SOUND = 16'h02D1;
  localparam logic [15:0] IO_CURSOR_LOW = 16'h02D2;
  localparam logic [15:0] IO_CURSOR_HIGH = 16'h02D3;
  localparam logic [15:0] IO_CONTROL = 16'h02D4;
  localparam logic [15:0] IO_KEYSTROKE = 16'h02D5;
  localparam logic [15:0] IO_TERMINAL_IDENTIFIER = 16'h02D6;
  localparam logic [15:0] IO_SEGMENT = 16'h02D7;
  localparam logic [15:0] IO_PAGE_LOW = 16'h02D8;
  localparam logic [15:0] IO_PAGE_HIGH = 16'h02D9;
  localparam logic [15:0] IO_PRINTER = 16'h02DA;
  localparam logic [15:0] IO_RSVD_FIRST = 16'h02DB;
  localparam logic [15:0] IO_RSVD_LAST = 16'h02DF;
  // Shared memory locations of the command mailbox
  localparam logic [15:0] MEM_CMD_FLAG = 16'h7E27;
  localparam logic [15:0] MEM_CMD_AREA = 16'h7F20;
  localparam logic [15:0] MEM_CMD_LAST = 16'h7F23;
  localparam int CMD_FLAG_BIT = 0;
  // Main status byte fields
  localparam int MS_AUX_CHANGE = 7;
  localparam int MS_TRIGGER = 6;
  localparam int MS_KEY_EMPTY = 5;
  localparam int MS_FATAL = 4;
  localparam int MS_CTRL_RESET = 3;
  localparam int MS_CMD_IRQ = 2;
  localparam int MS_BUF_MOD = 1;
  localparam int MS_CURSOR_SET = 0;
  // Auxiliary status byte fields
  localparam int AS_UNUSED = 7;
  localparam int AS_POLLED = 6;
  // Visual/sound alarm bit and control interrupt enable bit
  localparam int VS_ALARM = 0;
  localparam int CTL_IRQ_ENABLE = 0;
  localparam logic [7:0] INT_SOURCE_MASK = 8'h3F;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Identity bytes returned by the revision command (arbitrary values)
  localparam logic [7:0] REVISION_ID = 8'h5A;
  localparam logic [7:0] OEM_NUMBER = 8'hA5;
  // Command codes
  typedef enum logic [3:0] {
    CMD_READ_BUF = 4'h0, CMD_WRITE_BUF = 4'h1, CMD_STATUS = 4'h2,
    CMD_CLEAR_MAIN = 4'h3, CMD_KEYSTROKE = 4'h4, CMD_LIGHT_PEN = 4'h5,
    CMD_POWER_RESET = 4'h6, CMD_TRIG_DATA = 4'h7, CMD_TRIG_ADDR = 4'h8,
    CMD_ATTN_MASK = 4'h9, CMD_TERM_TYPE = 4'hA, CMD_AUX_RELAY = 4'hB,
    CMD_TERM_INFO = 4'hC, CMD_NOOP = 4'hD, CMD_REVISION = 4'hE,
    CMD_RESERVED = 4'hF
  } hsrw_cmd_type;
  // Task pass states
  typedef enum logic [2:0] {
    ST_STATUS = 3'b000, ST_CHECK = 3'b001, ST_FETCH = 3'b010,
    ST_EXEC = 3'b011, ST_DONE = 3'b100, ST_MAIL = 3'b101
  } hsrw_state_type;
  // Host bus as seen at the pins
  typedef struct packed {
    logic rd;
    logic wr;
    logic mem;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hsrw_host_bus_type;
  // Status supplied by the coax side
  typedef struct packed {
    logic trigger_match;
    logic buffer_modified;
    logic cursor_set;
    logic key_empty;
    logic ctrl_reset;
    logic [6:0] aux;
    logic [15:0] cursor;
  } hsrw_coax_type;
  // Requests passed to the coax side
  typedef struct packed {
    logic power_reset;
    logic ctrl_reset;
    logic polled;
    logic key_empty;
    logic cursor_change;
  } hsrw_mailbox_type;
  // Settings loaded by host commands
  typedef struct packed {
    logic [7:0] trigger_data;
    logic [7:0] trigger_mask;
    logic [15:0] trigger_addr;
    logic [7:0] attention_mask;
    logic [7:0] terminal_type;
    logic aux_relay;
  } hsrw_config_type;
endpackage : hsrw_pkg

// [hdl/hsrw_wum_reg.sv]
// Sticky flag register: hardware sets, writer clears under mask
`timescale 1ns/100ps
module hsrw_wum_reg #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] set,
  input wire logic clr_we,
  input wire logic [WIDTH-1:0] clr_mask,
  output logic [WIDTH-1:0] q
);
  import hsrw_pkg::*;

  // One flag per bit; a set in the clearing cycle wins
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic next_bit;
    assign next_bit = set[i] | (q[i] & ~(clr_we & clr_mask[i]));
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        q[i] <= 1'b0;
      end else if (ce) begin
        q[i] <= next_bit;
      end
    end
  end
endmodule : hsrw_wum_reg

// [hdl/hsrw_top.sv]
// Host status register window: host I/O registers and command mailbox
`timescale 1ns/100ps
module hsrw_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire hsrw_pkg::hsrw_host_bus_type host_bus,
  input wire hsrw_pkg::hsrw_coax_type coax,
  input wire logic [7:0] int_status_set,
  input wire logic [15:0] page_change_set,
  input wire logic [7:0] printer_status_set,
  input wire logic [7:0] visual_sound_in,
  input wire logic alarm_set,
  input wire logic ctl_load,
  input wire logic [7:0] ctl_data,
  output logic [7:0] host_rdata,
  output logic host_ack,
  output logic irq_level2,
  output logic [7:0] adapter_control,
  output logic [7:0] keystroke_code,
  output logic keystroke_valid,
  output logic [7:0] terminal_identifier,
  output logic [7:0] memory_segment,
  output hsrw_pkg::hsrw_mailbox_type mailbox_word,
  output logic mailbox_valid,
  output hsrw_pkg::hsrw_config_type cmd_config
);
  import hsrw_pkg::*;

  hsrw_host_bus_type bus_s1;
  hsrw_host_bus_type bus_s2;
  hsrw_host_bus_type bus_s3;
  hsrw_state_type state;
  hsrw_state_type next_state;
  hsrw_cmd_type cmd_code;
  hsrw_mailbox_type pending_change_accumulator;
  hsrw_mailbox_type exec_requests;
  logic [7:0] cmd_area [4];
  logic [7:0] result [4];
  logic cmd_request;
  logic [7:0] aux_prev;
  logic [7:0] aux_now;
  logic [7:0] main_now;
  logic [3:0] main_sticky;
  logic [3:0] main_set;
  logic aux_differs;
  logic [7:0] int_status;
  logic [15:0] page_change;
  logic [7:0] printer_status;
  logic [0:0] alarm_q;
  logic rd_pulse;
  logic wr_pulse;
  logic io_rd;
  logic io_wr;
  logic mem_rd;
  logic mem_wr;
  logic [1:0] area_idx;
  logic in_area;
  logic at_flag;
  logic [7:0] io_rdata;
  logic [7:0] mem_rdata;
  logic [7:0] visual_sound;
  logic clear_main;
  logic [3:0] clear_mask;
  logic flag_set;
  logic [7:0] arg1;
  logic [7:0] arg2;
  logic [7:0] arg3;

  // Host pins pass two flip-flops; a third stage feeds the edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_s1 <= '0;
      bus_s2 <= '0;
      bus_s3 <= '0;
    end else if (ce) begin
      bus_s1 <= host_bus;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end

  // One access per strobe rise, split into I/O and memory space
  assign rd_pulse = bus_s2.rd & ~bus_s3.rd;
  assign wr_pulse = bus_s2.wr & ~bus_s3.wr;
  assign io_rd = rd_pulse & ~bus_s2.mem;
  assign io_wr = wr_pulse & ~bus_s2.mem;
  assign mem_rd = rd_pulse & bus_s2.mem;
  assign mem_wr = wr_pulse & bus_s2.mem;
  assign in_area = (bus_s2.addr >= MEM_CMD_AREA) &&
                   (bus_s2.addr <= MEM_CMD_LAST);
  assign at_flag = (bus_s2.addr == MEM_CMD_FLAG);
  assign area_idx = bus_s2.addr[1:0];

  // Mask-cleared host registers
  hsrw_wum_reg #(.WIDTH(8)) u_int_status (
    .clk(clk), .rstn(rstn), .ce(ce),
    .set(int_status_set),
    .clr_we(io_wr && bus_s2.addr == IO_INT_STATUS),
    .clr_mask(bus_s2.wdata),
    .q(int_status)
  );
  hsrw_wum_reg #(.WIDTH(16)) u_page_change (
    .clk(clk), .rstn(rstn), .ce(ce),
    .set(page_change_set),
    .clr_we(io_wr && (bus_s2.addr == IO_PAGE_LOW ||
                      bus_s2.addr == IO_PAGE_HIGH)),
    .clr_mask(bus_s2.addr == IO_PAGE_LOW ? {8'h00, bus_s2.wdata} :
              {bus_s2.wdata, 8'h00}),
    .q(page_change)
  );
  hsrw_wum_reg #(.WIDTH(8)) u_printer (
    .clk(clk), .rstn(rstn), .ce(ce),
    .set(printer_status_set),
    .clr_we(io_wr && bus_s2.addr == IO_PRINTER),
    .clr_mask(bus_s2.wdata),
    .q(printer_status)
  );
  // Alarm bit: a write to the visual/sound register clears it whatever the data
  hsrw_wum_reg #(.WIDTH(1)) u_alarm (
    .clk(clk), .rstn(rstn), .ce(ce),
    .set(alarm_set),
    .clr_we(io_wr && bus_s2.addr == IO_VISUAL_SOUND),
    .clr_mask(1'b1),
    .q(alarm_q)
  );

  // Visual/sound view: coax bits with the sticky alarm in place
  always_comb begin
    visual_sound = visual_sound_in;
    visual_sound[VS_ALARM] = alarm_q[0];
  end

  // Host I/O read selection; write-only and reserved read zero
  assign io_rdata =
    (bus_s2.addr == IO_INT_STATUS) ? int_status :
    (bus_s2.addr == IO_VISUAL_SOUND) ? visual_sound :
    (bus_s2.addr == IO_CURSOR_LOW) ? coax.cursor[7:0] :
    (bus_s2.addr == IO_CURSOR_HIGH) ? coax.cursor[15:8] :
    (bus_s2.addr == IO_CONTROL) ? adapter_control :
    (bus_s2.addr == IO_PAGE_LOW) ? page_change[7:0] :
    (bus_s2.addr == IO_PAGE_HIGH) ? page_change[15:8] :
    (bus_s2.addr == IO_PRINTER) ? printer_status :
    BYTE_RESET;

  // Shared-memory read selection over the command area and flag
  assign mem_rdata =
    in_area ? cmd_area[area_idx] :
    at_flag ? {7'h00, cmd_request} :
    BYTE_RESET;

  // Read answer and acknowledge, one cycle after the strobe edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= BYTE_RESET;
      host_ack <= 1'b0;
    end else if (ce) begin
      host_ack <= rd_pulse | wr_pulse;
      if (io_rd) begin
        host_rdata <= io_rdata;
      end else if (mem_rd) begin
        host_rdata <= mem_rdata;
      end
    end
  end

  // Plain host registers; host write wins over a coax control load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adapter_control <= BYTE_RESET;
      keystroke_code <= BYTE_RESET;
      keystroke_valid <= 1'b0;
      terminal_identifier <= BYTE_RESET;
      memory_segment <= BYTE_RESET;
    end else if (ce) begin
      keystroke_valid <= io_wr && bus_s2.addr == IO_KEYSTROKE;
      if (io_wr && bus_s2.addr == IO_CONTROL) begin
        adapter_control <= bus_s2.wdata;
      end else if (ctl_load) begin
        adapter_control <= ctl_data;
      end
      if (io_wr && bus_s2.addr == IO_KEYSTROKE) begin
        keystroke_code <= bus_s2.wdata;
      end
      if (io_wr && bus_s2.addr == IO_TERMINAL_IDENTIFIER) begin
        terminal_identifier <= bus_s2.wdata;
      end
      if (io_wr && bus_s2.addr == IO_SEGMENT) begin
        memory_segment <= bus_s2.wdata;
      end
    end
  end

  // Level 2 interrupt from enabled interrupt sources
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_level2 <= 1'b0;
    end else if (ce) begin
      irq_level2 <= adapter_control[CTL_IRQ_ENABLE] &
                    (|(int_status & INT_SOURCE_MASK));
    end
  end

  // Status assembly; aux bit 7 unused, main bits 4 and 2 held low
  assign aux_now = {1'b0, coax.aux};
  assign aux_differs = (state == ST_STATUS) && (aux_now != aux_prev);
  assign main_set = {aux_differs, coax.trigger_match,
                     coax.buffer_modified, coax.cursor_set};
  assign main_now = {main_sticky[3], main_sticky[2], coax.key_empty,
                     1'b0, coax.ctrl_reset, 1'b0,
                     main_sticky[1], main_sticky[0]};

  // Sticky main bits, cleared only by the clear-status command
  assign clear_main = (state == ST_EXEC) && (cmd_code == CMD_CLEAR_MAIN);
  assign clear_mask = {arg1[MS_AUX_CHANGE], arg1[MS_TRIGGER],
                       arg1[MS_BUF_MOD], arg1[MS_CURSOR_SET]};
  hsrw_wum_reg #(.WIDTH(4)) u_main_sticky (
    .clk(clk), .rstn(rstn), .ce(ce),
    .set(main_set),
    .clr_we(clear_main),
    .clr_mask(clear_mask),
    .q(main_sticky)
  );

  // Previous aux byte kept for the change compare
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_prev <= BYTE_RESET;
    end else if (ce && state == ST_STATUS) begin
      aux_prev <= aux_now;
    end
  end

  // Arguments come straight from the command area
  assign arg1 = cmd_area[1];
  assign arg2 = cmd_area[2];
  assign arg3 = cmd_area[3];

  // Requests raised by the command in hand, posted later
  always_comb begin
    exec_requests = '0;
    if (state == ST_EXEC) begin
      if (cmd_code == CMD_CLEAR_MAIN) begin
        exec_requests.cursor_change = arg1[MS_CURSOR_SET];
        exec_requests.key_empty = arg1[MS_KEY_EMPTY];
        exec_requests.ctrl_reset = arg1[MS_CTRL_RESET];
      end else if (cmd_code == CMD_STATUS) begin
        exec_requests.polled = 1'b1;
      end else if (cmd_code == CMD_POWER_RESET) begin
        exec_requests.power_reset = 1'b1;
      end
    end
  end

  // Result bytes, main status always first
  always_comb begin
    result[0] = main_now;
    result[1] = arg1;
    result[2] = arg2;
    result[3] = arg3;
    case (cmd_code)
      CMD_STATUS: begin
        result[1] = coax.cursor[7:0];
        result[2] = coax.cursor[15:8];
        result[3] = aux_now;
      end
      CMD_TERM_INFO: begin
        result[1] = cmd_config.terminal_type;
        result[2] = terminal_identifier;
        result[3] = BYTE_RESET;
      end
      CMD_REVISION: begin
        result[1] = REVISION_ID;
        result[2] = OEM_NUMBER;
        result[3] = BYTE_RESET;
      end
      default: begin
        result[1] = arg1;
      end
    endcase
  end

  // Task pass sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_STATUS: next_state = ST_CHECK;
      ST_CHECK: next_state = cmd_request ? ST_FETCH : ST_MAIL;
      ST_FETCH: next_state = ST_EXEC;
      ST_EXEC: next_state = ST_DONE;
      ST_DONE: next_state = ST_MAIL;
      ST_MAIL: next_state = ST_STATUS;
      default: next_state = ST_STATUS;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_STATUS;
      cmd_code <= CMD_READ_BUF;
    end else if (ce) begin
      state <= next_state;
      if (state == ST_FETCH) begin
        cmd_code <= hsrw_cmd_type'(cmd_area[0][3:0]);
      end
    end
  end

  // Command area: device write-back has priority over host writes
  for (genvar i = 0; i < 4; i++) begin : g_area
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        cmd_area[i] <= BYTE_RESET;
      end else if (ce) begin
        if (state == ST_DONE) begin
          cmd_area[i] <= result[i];
        end else if (mem_wr && in_area && area_idx == 2'(i)) begin
          cmd_area[i] <= bus_s2.wdata;
        end
      end
    end
  end

  // Request flag: host sets, completion clears, a set wins
  assign flag_set = mem_wr && at_flag && bus_s2.wdata[CMD_FLAG_BIT];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_request <= 1'b0;
    end else if (ce) begin
      if (flag_set) begin
        cmd_request <= 1'b1;
      end else if (state == ST_DONE) begin
        cmd_request <= 1'b0;
      end
    end
  end

  // Settings loaded by the configuration commands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_config <= '0;
    end else if (ce && state == ST_EXEC) begin
      case (cmd_code)
        CMD_TRIG_DATA: begin
          cmd_config.trigger_data <= arg1;
          cmd_config.trigger_mask <= arg2;
        end
        CMD_TRIG_ADDR: begin
          cmd_config.trigger_addr <= {arg2, arg1};
        end
        CMD_ATTN_MASK: begin
          cmd_config.attention_mask <= arg1;
        end
        CMD_TERM_TYPE: begin
          cmd_config.terminal_type <= arg1;
        end
        CMD_AUX_RELAY: begin
          cmd_config.aux_relay <= arg1[0];
        end
        default: begin
          cmd_config.aux_relay <= cmd_config.aux_relay;
        end
      endcase
    end
  end

  // Requests gather over the pass and post once at its end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_change_accumulator <= '0;
      mailbox_word <= '0;
      mailbox_valid <= 1'b0;
    end else if (ce) begin
      mailbox_valid <= 1'b0;
      if (state == ST_MAIL) begin
        pending_change_accumulator <= '0;
        if (pending_change_accumulator != '0) begin
          mailbox_word <= pending_change_accumulator;
          mailbox_valid <= 1'b1;
        end
      end else begin
        pending_change_accumulator <=
          pending_change_accumulator | exec_requests;
      end
    end
  end
endmodule : hsrw_top

// [dv/hsrw_host_model.sv]
// Host processor model: strobed I/O and shared memory cycles
`timescale 1ns/100ps
module hsrw_host_model (
  input wire logic clk,
  input wire logic [7:0] host_rdata,
  input wire logic host_ack,
  output hsrw_pkg::hsrw_host_bus_type host_bus
);
  import hsrw_pkg::*;
  initial begin
    host_bus = '0;
  end
  // Strobe and qualifiers held until ack is sampled, then released
  task automatic access(input logic is_rd, input logic is_mem,
      input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    host_bus <= '{rd: is_rd, wr: !is_rd, mem: is_mem, addr: a, wdata: d};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (host_ack === 1'b1);
    end
    q = host_rdata;
    // Released strobes go low; the other lines show the inverse, never the last value
    host_bus <= '{rd: 1'b0, wr: 1'b0, mem: !is_mem, addr: ~a, wdata: ~d};
    repeat (3) @(posedge clk);
  endtask : access
endmodule : hsrw_host_model

// [dv/hsrw_top_assertions.sv]
// Checker of host access, register and mailbox behaviour
`timescale 1ns/100ps
module hsrw_top_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire hsrw_pkg::hsrw_host_bus_type host_bus,
  input wire hsrw_pkg::hsrw_coax_type coax,
  input wire logic [7:0] host_rdata,
  input wire logic host_ack,
  input wire logic irq_level2,
  input wire logic [7:0] adapter_control,
  input wire logic [7:0] keystroke_code,
  input wire logic keystroke_valid,
  input wire logic [7:0] terminal_identifier,
  input wire logic [7:0] memory_segment,
  input wire hsrw_pkg::hsrw_mailbox_type mailbox_word,
  input wire logic mailbox_valid
);
  import hsrw_pkg::*;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // I/O space write and acknowledged I/O read
  logic io_wr;
  logic io_rd_ack;
  assign io_wr = host_bus.wr && !host_bus.mem;
  assign io_rd_ack = host_ack && host_bus.rd && !host_bus.mem;
  // A posting is followed by at least two quiet cycles
  sequence post_s;
    mailbox_valid ##1 !mailbox_valid [*2];
  endsequence
  a_ack_single_pulse: assert property (host_ack |=> !host_ack)
    else $error("host ack longer than one cycle");
  a_ack_needs_strobe: assert property (
    host_ack |-> host_bus.rd || host_bus.wr)
    else $error("host ack without a strobe");
  a_rsvd_read_zero: assert property (io_rd_ack &&
    (host_bus.addr >= IO_KEYSTROKE && host_bus.addr <= IO_SEGMENT ||
     host_bus.addr >= IO_RSVD_FIRST && host_bus.addr <= IO_RSVD_LAST)
    |-> host_rdata == 8'h00)
    else $error("write-only or reserved read not zero");
  a_cursor_read: assert property (io_rd_ack &&
    host_bus.addr == IO_CURSOR_LOW |-> host_rdata == coax.cursor[7:0])
    else $error("cursor low read wrong");
  a_control_write: assert property (host_ack && io_wr &&
    host_bus.addr == IO_CONTROL |-> adapter_control == host_bus.wdata)
    else $error("control write not taken");
  a_keystroke_cause: assert property (keystroke_valid |-> io_wr &&
    host_bus.addr == IO_KEYSTROKE && keystroke_code == host_bus.wdata)
    else $error("keystroke valid without matching write");
  a_segment_write_only: assert property ($changed(memory_segment)
    |-> io_wr && host_bus.addr == IO_SEGMENT)
    else $error("segment changed without host write");
  a_terminal_write_only: assert property (
    $changed(terminal_identifier)
    |-> io_wr && host_bus.addr == IO_TERMINAL_IDENTIFIER)
    else $error("terminal_identifier changed without host write");
  a_irq_masked: assert property (
    !adapter_control[CTL_IRQ_ENABLE] |=> !irq_level2)
    else $error("interrupt raised while disabled");
  a_mailbox_spacing: assert property (mailbox_valid |-> post_s)
    else $error("mailbox posted twice in a pass");
  a_mailbox_nonzero: assert property (
    mailbox_valid |-> mailbox_word != 5'h00)
    else $error("empty mailbox posted");
  a_mailbox_held: assert property ($changed(mailbox_word)
    |-> mailbox_valid)
    else $error("mailbox changed without posting");
endmodule : hsrw_top_assertions
bind hsrw_top hsrw_top_assertions i_chk (.clk(clk), .rstn(rstn),
  .host_bus(host_bus), .coax(coax), .host_rdata(host_rdata),
  .host_ack(host_ack), .irq_level2(irq_level2),
  .adapter_control(adapter_control), .keystroke_code(keystroke_code),
  .keystroke_valid(keystroke_valid),
  .terminal_identifier(terminal_identifier),
  .memory_segment(memory_segment), .mailbox_word(mailbox_word),
  .mailbox_valid(mailbox_valid));

// [dv/testbench.sv]
// Self-checking bench of the host status register window
`timescale 1ns/100ps
module testbench;
  import hsrw_pkg::*;
  typedef struct packed {
    logic rd;
    logic mem;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] want;
  } hsrw_row_type;
  localparam logic RD = 1'b1;
  localparam logic WR = 1'b0;
  localparam logic IO = 1'b0;
  localparam logic MEM = 1'b1;
  localparam int NROW = 26;
  // Host cycles and expected read data after one round of set pulses
  localparam hsrw_row_type ROWS [NROW] = '{
    '{RD, IO, IO_INT_STATUS, 8'h00, 8'h05},
    '{WR, IO, IO_INT_STATUS, 8'h01, 8'h00},
    '{RD, IO, IO_INT_STATUS, 8'h00, 8'h04},
    '{RD, IO, IO_VISUAL_SOUND, 8'h00, 8'hF1},
    '{WR, IO, IO_VISUAL_SOUND, 8'h00, 8'h00},
    '{RD, IO, IO_VISUAL_SOUND, 8'h00, 8'hF0},
    '{RD, IO, IO_CURSOR_HIGH, 8'h00, 8'h12},
    '{WR, IO, IO_CURSOR_LOW, 8'hFF, 8'h00},
    '{RD, IO, IO_CURSOR_LOW, 8'h00, 8'h34},
    '{WR, IO, IO_CONTROL, 8'hA5, 8'h00},
    '{RD, IO, IO_CONTROL, 8'h00, 8'hA5},
    '{WR, IO, IO_KEYSTROKE, 8'h77, 8'h00},
    '{RD, IO, IO_KEYSTROKE, 8'h00, 8'h00},
    '{WR, IO, IO_TERMINAL_IDENTIFIER, 8'h3E, 8'h00},
    '{WR, IO, IO_SEGMENT, 8'hCE, 8'h00},
    '{RD, IO, IO_SEGMENT, 8'h00, 8'h00},
    '{RD, IO, IO_PAGE_LOW, 8'h00, 8'h01},
    '{RD, IO, IO_PAGE_HIGH, 8'h00, 8'h80},
    '{WR, IO, IO_PAGE_HIGH, 8'h80, 8'h00},
    '{RD, IO, IO_PAGE_HIGH, 8'h00, 8'h00},
    '{RD, IO, IO_PRINTER, 8'h00, 8'h40},
    '{WR, IO, IO_RSVD_FIRST, 8'h11, 8'h00},
    '{RD, IO, IO_RSVD_LAST, 8'h00, 8'h00},
    '{WR, MEM, MEM_CMD_LAST, 8'h3C, 8'h00},
    '{RD, MEM, MEM_CMD_LAST, 8'h00, 8'h3C},
    '{RD, MEM, 16'h7E28, 8'h00, 8'h00}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  hsrw_host_bus_type host_bus;
  hsrw_coax_type coax = '{key_empty: 1'b1, aux: 7'h2B, cursor: 16'h1234,
    default: '0};
  logic [7:0] int_status_set = 8'h00;
  logic [15:0] page_change_set = 16'h0000;
  logic [7:0] printer_status_set = 8'h00;
  logic [7:0] visual_sound_in = 8'hF0;
  logic alarm_set = 1'b0;
  logic ctl_load = 1'b0;
  logic [7:0] ctl_data = 8'h00;
  logic [7:0] host_rdata;
  logic host_ack;
  logic irq_level2;
  logic [7:0] adapter_control;
  logic [7:0] keystroke_code;
  logic keystroke_valid;
  logic [7:0] terminal_identifier;
  logic [7:0] memory_segment;
  hsrw_mailbox_type mailbox_word;
  logic mailbox_valid;
  hsrw_config_type cmd_config;
  logic [7:0] rdata;
  logic ok;
  int err_total = 0;
  int n_compared = 0;
  int i;
  hsrw_top i_dut (.clk(clk), .rstn(rstn), .ce(ce), .host_bus(host_bus),
    .coax(coax), .int_status_set(int_status_set),
    .page_change_set(page_change_set),
    .printer_status_set(printer_status_set),
    .visual_sound_in(visual_sound_in), .alarm_set(alarm_set),
    .ctl_load(ctl_load), .ctl_data(ctl_data), .host_rdata(host_rdata),
    .host_ack(host_ack), .irq_level2(irq_level2),
    .adapter_control(adapter_control), .keystroke_code(keystroke_code),
    .keystroke_valid(keystroke_valid),
    .terminal_identifier(terminal_identifier),
    .memory_segment(memory_segment), .mailbox_word(mailbox_word),
    .mailbox_valid(mailbox_valid), .cmd_config(cmd_config));
  hsrw_host_model i_host (.clk(clk), .host_rdata(host_rdata),
    .host_ack(host_ack), .host_bus(host_bus));
  // Free-running clock
  always #10 clk = ~clk;
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Compare one result and count it
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk
  // One host cycle; a missing ack ends the run
  task automatic io(input logic r, input logic m, input logic [15:0] a,
      input logic [7:0] d);
    i_host.access(r, m, a, d, rdata, ok);
    if (!ok) begin
      err_total++;
      end_sim();
    end
  endtask : io
  task automatic rchk(input logic [15:0] a, input logic [7:0] want);
    io(RD, MEM, a, 8'h00);
    chk(64'(rdata), 64'(want));
  endtask : rchk
  // Arguments, then code, then the request flag; wait for it to clear
  task automatic cmd(input logic [3:0] code, input logic [7:0] a1,
      input logic [7:0] a2);
    int n;
    io(WR, MEM, MEM_CMD_AREA + 16'h0001, a1);
    io(WR, MEM, MEM_CMD_AREA + 16'h0002, a2);
    io(WR, MEM, MEM_CMD_AREA, {4'h0, code});
    io(WR, MEM, MEM_CMD_FLAG, 8'h01);
    // Stale read data must not skip the poll
    rdata = 8'h01;
    for (n = 0; n < 20 && rdata[CMD_FLAG_BIT] !== 1'b0; n++) begin
      io(RD, MEM, MEM_CMD_FLAG, 8'h00);
    end
    chk(64'(rdata[CMD_FLAG_BIT]), 64'h0);
    if (rdata[CMD_FLAG_BIT] !== 1'b0) begin
      end_sim();
    end
  endtask : cmd
  // One-cycle pulses on every set input
  task automatic pulse_sets;
    @(posedge clk);
    int_status_set <= 8'h05;
    page_change_set <= 16'h8001;
    printer_status_set <= 8'h40;
    alarm_set <= 1'b1;
    @(posedge clk);
    int_status_set <= 8'h00;
    page_change_set <= 16'h0000;
    printer_status_set <= 8'h00;
    alarm_set <= 1'b0;
  endtask : pulse_sets
  task automatic chk_reset;
    chk(64'({irq_level2, mailbox_word, adapter_control,
      memory_segment}), 64'h0);
    chk(64'(cmd_config), 64'h0);
  endtask : chk_reset
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_reset();
    pulse_sets();
    for (i = 0; i < NROW; i++) begin
      io(ROWS[i].rd, ROWS[i].mem, ROWS[i].addr, ROWS[i].wdata);
      if (ROWS[i].rd) begin
        chk(64'(rdata), 64'(ROWS[i].want));
      end
    end
    chk(64'(irq_level2), 64'h1);
    chk(64'({keystroke_code, memory_segment}), 64'h77CE);
    io(WR, IO, IO_INT_STATUS, 8'h04);
    chk(64'(irq_level2), 64'h0);
    // Adapter side loads control with interrupts masked
    @(posedge clk);
    ctl_data <= 8'h3C;
    ctl_load <= 1'b1;
    @(posedge clk);
    ctl_load <= 1'b0;
    pulse_sets();
    repeat (4) @(posedge clk);
    chk(64'(irq_level2), 64'h0);
    io(RD, IO, IO_CONTROL, 8'h00);
    chk(64'(rdata), 64'h3C);
    // Code without request flag must not run
    io(WR, MEM, MEM_CMD_AREA, 8'h06);
    repeat (30) @(posedge clk);
    chk(64'(mailbox_word), 64'h0);
    for (i = 0; i < 16; i++) begin
      cmd(4'(i), 8'h00, 8'h00);
    end
    @(posedge clk);
    coax.trigger_match <= 1'b1;
    coax.buffer_modified <= 1'b1;
    coax.cursor_set <= 1'b1;
    @(posedge clk);
    coax.trigger_match <= 1'b0;
    coax.buffer_modified <= 1'b0;
    coax.cursor_set <= 1'b0;
    cmd(CMD_NOOP, 8'h00, 8'h00);
    rchk(MEM_CMD_AREA, 8'hE3);
    cmd(CMD_CLEAR_MAIN, 8'hE3, 8'h00);
    chk(64'(mailbox_word), 64'h03);
    cmd(CMD_NOOP, 8'h00, 8'h00);
    rchk(MEM_CMD_AREA, 8'h20);
    cmd(CMD_STATUS, 8'h00, 8'h00);
    rchk(MEM_CMD_AREA + 16'h0001, 8'h34);
    rchk(MEM_CMD_AREA + 16'h0002, 8'h12);
    rchk(MEM_CMD_LAST, 8'h2B);
    chk(64'(mailbox_word), 64'h04);
    cmd(CMD_POWER_RESET, 8'h00, 8'h00);
    chk(64'(mailbox_word), 64'h10);
    cmd(CMD_TRIG_DATA, 8'hC3, 8'h0F);
    chk(64'(cmd_config.trigger_data), 64'hC3);
    chk(64'(cmd_config.trigger_mask), 64'h0F);
    cmd(CMD_TRIG_ADDR, 8'h34, 8'h12);
    chk(64'(cmd_config.trigger_addr), 64'h1234);
    cmd(CMD_TERM_TYPE, 8'h9C, 8'h00);
    cmd(CMD_TERM_INFO, 8'h00, 8'h00);
    rchk(MEM_CMD_AREA + 16'h0001, 8'h9C);
    rchk(MEM_CMD_AREA + 16'h0002, 8'h3E);
    cmd(CMD_REVISION, 8'h00, 8'h00);
    rchk(MEM_CMD_AREA + 16'h0001, REVISION_ID);
    rchk(MEM_CMD_AREA + 16'h0002, OEM_NUMBER);
    // Second reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_reset();
    end_sim();
  end
endmodule : testbench
